// [hw/ppg_pair_pkg.sv]
// Constants for the dual 8-bit pulse generator / 16-bit timer pair.
// Assumes a 32-bit AXI4-Lite register port with 6 address bits.
package ppg_pair_pkg;
	localparam int ADDR_W = 6;
	// Byte offsets of the registers
	localparam logic [5:0] OFF_MODE_A   = 6'h00;
	localparam logic [5:0] OFF_MODE_B   = 6'h04;
	localparam logic [5:0] OFF_PAIR     = 6'h08;
	localparam logic [5:0] OFF_PERIOD_A = 6'h0C;
	localparam logic [5:0] OFF_DUTY_A   = 6'h10;
	localparam logic [5:0] OFF_PERIOD_B = 6'h14;
	localparam logic [5:0] OFF_DUTY_B   = 6'h18;
	localparam logic [5:0] OFF_STATUS   = 6'h1C;
	// Mode register fields
	localparam int MODE_LSB  = 0;
	localparam int EXT_BIT   = 2;
	localparam int CLK_LSB   = 3;
	localparam int DB_BIT    = 6;
	localparam int LEVEL_BIT = 7;
	localparam logic [1:0] MODE_PPG = 2'h2;
	// Pair control register fields
	localparam int RUN_A_BIT   = 0;
	localparam int RUN_B_BIT   = 1;
	localparam int CASCADE_BIT = 2;
	localparam int AND_BIT     = 3;
	// Reset values
	localparam logic [7:0] RST_MODE    = 8'h00;
	localparam logic [7:0] RST_COMPARE = 8'hFF;
	localparam logic [7:0] RST_COUNT   = 8'h00;
	localparam logic [3:0] RST_PAIR    = 4'h0;
	// Prescaler width: longest source divide is 2**11
	localparam int PRE_W = 11;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [hw/ppg_pair.sv]
// Dual 8-bit pulse generator timer with 16-bit cascade, AXI4-Lite slave.
// Assumes one clock, synchronous active-high reset, bus in the clk domain.
//
// Summary of operation
// - Timer A pulse mode: mode field 10, no cascade, internal clock.
// - Timer A mode register writes ignored while timer A runs.
// - Initial-level bit sets idle level: 0 low, 1 high.
// - Stopped timer drives its pulse output at the initial level.
// - AND-select drives pin with A AND B pulse outputs.
// - Running counter increments once per selected source tick.
// - Duty match toggles output away from idle level; counting continues.
// - Period match restores idle level and raises timer interrupt.
// - Clearing run stops counter, zeroes it, restores idle level.
// - Buffered writes while running load into compare at interrupt.
// - Buffered compare reads return the last written value.
// - Buffered writes while stopped update buffer and compare together.
// - Unbuffered writes apply at once; lower values wait for wrap.
// - Unbuffered write equal to count matches right after the write.
// - Timer B behaves like timer A with its own registers.
// - Cascade joins counters; only timer B settings apply.
// - Wide mode: B mode field 00/01, internal clock, B clock select.
// - Wide compare: A period low, B period high; high write commits.
// - Wide match raises B interrupt, clears counter, keeps counting.
// - Clearing B run in wide mode stops and zeroes counter.
// - Buffered wide writes while running load at next match.
// - Buffered wide writes while stopped update compare at once.
// - Wide compare reads return last value written.
`timescale 1ns/1ps
`default_nettype none
module ppg_pair
(
	input  wire logic                       clk,     // 200 MHz clock
	input  wire logic                       sys_rst, // Sync reset
	input  wire logic [ppg_pair_pkg::ADDR_W-1:0] awaddr, // Write addr
	input  wire logic                       awvalid, // Write addr valid
	output var  logic                       awready, // Write addr ready
	input  wire logic [31:0]                wdata,   // Write data
	input  wire logic [3:0]                 wstrb,   // Byte enables
	input  wire logic                       wvalid,  // Write data valid
	output var  logic                       wready,  // Write data ready
	output var  logic [1:0]                 bresp,   // Write response
	output var  logic                       bvalid,  // Response valid
	input  wire logic                       bready,  // Response ready
	input  wire logic [ppg_pair_pkg::ADDR_W-1:0] araddr, // Read addr
	input  wire logic                       arvalid, // Read addr valid
	output var  logic                       arready, // Read addr ready
	output var  logic [31:0]                rdata,   // Read data
	output var  logic [1:0]                 rresp,   // Read response
	output var  logic                       rvalid,  // Read data valid
	input  wire logic                       rready,  // Read data ready
	output var  logic                       pulse_output_pin_a, // A pin
	output var  logic                       pulse_output_pin_b, // B pin
	output var  logic                       timer_a_interrupt,  // A pulse
	output var  logic                       timer_b_interrupt   // B pulse
);

	function automatic logic tick_sel
	(
		input logic [2:0]                    sel,
		input logic [ppg_pair_pkg::PRE_W-1:0] pre
	);
		case (sel)
			3'h0: tick_sel = &pre[10:0];
			3'h1: tick_sel = &pre[9:0];
			3'h2: tick_sel = &pre[7:0];
			3'h3: tick_sel = &pre[5:0];
			3'h4: tick_sel = &pre[3:0];
			3'h5: tick_sel = &pre[1:0];
			3'h6: tick_sel = pre[0];
			default: tick_sel = 1'b1;
		endcase
	endfunction

	logic [7:0]  mode_reg [2];
	logic [7:0]  pd_buf   [2];
	logic [7:0]  dt_buf   [2];
	logic [7:0]  pd_act   [2];
	logic [7:0]  dt_act   [2];
	logic [7:0]  cnt      [2];
	logic [15:0] wide_buf;
	logic [1:0]  run;
	logic        cascade;
	logic        and_sel;
	logic [1:0]  lvl;
	logic [1:0]  clr_pend;
	logic [1:0]  mdt_q;
	logic [1:0]  mpd_q;
	logic        wide_q;
	logic        wide_clr;
	logic [ppg_pair_pkg::PRE_W-1:0] pre;

	// Bus side state
	logic        aw_full;
	logic        w_full;
	logic [ppg_pair_pkg::ADDR_W-1:0] wa;
	logic [7:0]  wd;
	logic        wen;

	wire aw_hs = awvalid & awready;
	wire w_hs = wvalid & wready;
	wire ar_hs = arvalid & arready;
	wire do_write = aw_full & w_full & ~bvalid;
	wire [5:0] wa_al = {wa[5:2], 2'b00};
	wire [5:0] ra_al = {araddr[5:2], 2'b00};
	wire w_ok = do_write & wen;
	wire wr_mode_a = w_ok & (wa_al == ppg_pair_pkg::OFF_MODE_A);
	wire wr_mode_b = w_ok & (wa_al == ppg_pair_pkg::OFF_MODE_B);
	wire wr_pair = w_ok & (wa_al == ppg_pair_pkg::OFF_PAIR);
	wire [1:0] wr_pd = {w_ok & (wa_al == ppg_pair_pkg::OFF_PERIOD_B),
		w_ok & (wa_al == ppg_pair_pkg::OFF_PERIOD_A)};
	wire [1:0] wr_dt = {w_ok & (wa_al == ppg_pair_pkg::OFF_DUTY_B),
		w_ok & (wa_al == ppg_pair_pkg::OFF_DUTY_A)};
	wire w_mapped = wa_al <= ppg_pair_pkg::OFF_STATUS;
	wire r_mapped = ra_al <= ppg_pair_pkg::OFF_STATUS;

	// Per-timer decode
	logic [1:0] ppg_on;
	logic [1:0] tick;
	logic [1:0] buffered;
	logic [1:0] db;
	logic [1:0] init;
	logic [1:0] ev_dt;
	logic [1:0] ev_pd;
	logic [1:0] m_dt;
	logic [1:0] m_pd;
	logic [1:0] next_lvl;
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_dec
			wire [7:0] mr = mode_reg[gi];
			assign ppg_on[gi] = run[gi] & ~cascade & ~mr[ppg_pair_pkg::EXT_BIT]
				& (mr[ppg_pair_pkg::MODE_LSB+:2] == ppg_pair_pkg::MODE_PPG);
			assign tick[gi] = tick_sel(mr[ppg_pair_pkg::CLK_LSB+:3], pre);
			assign db[gi] = mr[ppg_pair_pkg::DB_BIT];
			assign init[gi] = mr[ppg_pair_pkg::LEVEL_BIT];
			assign buffered[gi] = db[gi] & run[gi];
			assign m_dt[gi] = cnt[gi] == dt_act[gi];
			assign m_pd[gi] = cnt[gi] == pd_act[gi];
			// Edge of equality: also catches a write equal to the count
			assign ev_dt[gi] = ppg_on[gi] & m_dt[gi] & ~mdt_q[gi];
			assign ev_pd[gi] = ppg_on[gi] & m_pd[gi] & ~mpd_q[gi];
			assign next_lvl[gi] = (~ppg_on[gi] | ev_pd[gi]) ? init[gi]
				: (ev_dt[gi] ? ~init[gi] : lvl[gi]);
		end
	endgenerate

	wire wide_on = run[1] & cascade & ~mode_reg[1][ppg_pair_pkg::EXT_BIT]
		& ~mode_reg[1][ppg_pair_pkg::MODE_LSB+1];
	wire wide_buffered = db[1] & run[1];
	wire [15:0] wide_cnt = {cnt[1], cnt[0]};
	wire [15:0] wide_act = {pd_act[1], pd_act[0]};
	wire wide_m = wide_cnt == wide_act;
	wire wide_ev = wide_on & wide_m & ~wide_q;
	wire [15:0] wide_new = {wd, pd_buf[0]};

	// Write address/data are taken in either order, held until used
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= ppg_pair_pkg::RESP_OKAY;
			wa <= '0;
			wd <= 8'h00;
			wen <= 1'b0;
		end
		else
		begin
			aw_full <= (aw_full | aw_hs) & ~do_write;
			w_full <= (w_full | w_hs) & ~do_write;
			awready <= ~(aw_full | aw_hs) | do_write;
			wready <= ~(w_full | w_hs) | do_write;
			if (aw_hs)
				wa <= awaddr;
			if (w_hs)
			begin
				wd <= wdata[7:0];
				wen <= wstrb[0];
			end
			if (do_write)
			begin
				bvalid <= 1'b1;
				bresp <= w_mapped ? ppg_pair_pkg::RESP_OKAY
					: ppg_pair_pkg::RESP_SLVERR;
			end
			else if (bready)
				bvalid <= 1'b0;
		end
	end

	// Read mux; compare reads show the last written value
	logic [31:0] rd_mux;
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		case (ra_al)
			ppg_pair_pkg::OFF_MODE_A:   rd_mux[7:0] = mode_reg[0];
			ppg_pair_pkg::OFF_MODE_B:   rd_mux[7:0] = mode_reg[1];
			ppg_pair_pkg::OFF_PAIR:
				rd_mux[3:0] = {and_sel, cascade, run};
			ppg_pair_pkg::OFF_PERIOD_A: rd_mux[7:0] = pd_buf[0];
			ppg_pair_pkg::OFF_DUTY_A:   rd_mux[7:0] = dt_buf[0];
			ppg_pair_pkg::OFF_PERIOD_B: rd_mux[7:0] = pd_buf[1];
			ppg_pair_pkg::OFF_DUTY_B:   rd_mux[7:0] = dt_buf[1];
			ppg_pair_pkg::OFF_STATUS:
				rd_mux[17:0] = {pulse_output_pin_b, pulse_output_pin_a,
					cnt[1], cnt[0]};
			default:                    rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= ppg_pair_pkg::RESP_OKAY;
		end
		else if (ar_hs)
		begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_mux;
			rresp <= r_mapped ? ppg_pair_pkg::RESP_OKAY
				: ppg_pair_pkg::RESP_SLVERR;
		end
		else if (~rvalid | rready)
		begin
			arready <= 1'b1;
			rvalid <= 1'b0;
		end
	end

	// Control registers; a running timer keeps its mode frozen
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			mode_reg[0] <= ppg_pair_pkg::RST_MODE;
			mode_reg[1] <= ppg_pair_pkg::RST_MODE;
			{and_sel, cascade, run} <= ppg_pair_pkg::RST_PAIR;
		end
		else
		begin
			if (wr_mode_a & ~run[0])
				mode_reg[0] <= wd;
			if (wr_mode_b & ~run[1])
				mode_reg[1] <= wd;
			if (wr_pair)
			begin
				run <= {wd[ppg_pair_pkg::RUN_B_BIT], wd[ppg_pair_pkg::RUN_A_BIT]};
				cascade <= wd[ppg_pair_pkg::CASCADE_BIT];
				and_sel <= wd[ppg_pair_pkg::AND_BIT];
			end
		end
	end

	// Compare registers and their buffers
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			for (int i = 0; i < 2; i++)
			begin
				pd_buf[i] <= ppg_pair_pkg::RST_COMPARE;
				dt_buf[i] <= ppg_pair_pkg::RST_COMPARE;
				pd_act[i] <= ppg_pair_pkg::RST_COMPARE;
				dt_act[i] <= ppg_pair_pkg::RST_COMPARE;
			end
			wide_buf <= {ppg_pair_pkg::RST_COMPARE, ppg_pair_pkg::RST_COMPARE};
		end
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				if (ev_pd[i] & db[i])
				begin
					pd_act[i] <= pd_buf[i];
					dt_act[i] <= dt_buf[i];
				end
				if (wr_dt[i])
				begin
					dt_buf[i] <= wd;
					if (~buffered[i])
						dt_act[i] <= wd;
				end
				if (wr_pd[i])
				begin
					pd_buf[i] <= wd;
					if (~buffered[i] & ~cascade)
						pd_act[i] <= wd;
				end
			end
			if (wide_ev & db[1])
				{pd_act[1], pd_act[0]} <= wide_buf;
			// Buffer tracks every high write, so cascade may be set last
			if (wr_pd[1])
				wide_buf <= wide_new;
			if (wr_pd[1] & cascade & ~wide_buffered)
				{pd_act[1], pd_act[0]} <= wide_new;
		end
	end

	// Counters, match history and pulse levels
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			pre <= '0;
			for (int i = 0; i < 2; i++)
				cnt[i] <= ppg_pair_pkg::RST_COUNT;
			clr_pend <= 2'h0;
			mdt_q <= 2'h0;
			mpd_q <= 2'h0;
			lvl <= 2'h0;
			wide_q <= 1'b0;
			wide_clr <= 1'b0;
		end
		else
		begin
			pre <= pre + 1'b1;
			wide_q <= wide_m & wide_on;
			for (int i = 0; i < 2; i++)
			begin
				mdt_q[i] <= m_dt[i] & ppg_on[i];
				mpd_q[i] <= m_pd[i] & ppg_on[i];
				lvl[i] <= next_lvl[i];
			end
			if (wide_on)
			begin
				clr_pend <= 2'h0;
				if (tick[1])
				begin
					// A match seen between ticks clears the count on the next tick
					if (wide_clr | wide_ev)
						{cnt[1], cnt[0]} <= 16'h0000;
					else
						{cnt[1], cnt[0]} <= wide_cnt + 16'h0001;
					wide_clr <= 1'b0;
				end
				else if (wide_ev)
					wide_clr <= 1'b1;
			end
			else
			begin
				wide_clr <= 1'b0;
				for (int i = 0; i < 2; i++)
				begin
					if (~ppg_on[i])
					begin
						cnt[i] <= ppg_pair_pkg::RST_COUNT;
						clr_pend[i] <= 1'b0;
					end
					else if (tick[i])
					begin
						if (clr_pend[i] | ev_pd[i])
							cnt[i] <= 8'h00;
						else
							cnt[i] <= cnt[i] + 8'h01;
						clr_pend[i] <= 1'b0;
					end
					else if (ev_pd[i])
						clr_pend[i] <= 1'b1;
				end
			end
		end
	end

	// Pins and interrupt pulses, all registered
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			pulse_output_pin_a <= 1'b0;
			pulse_output_pin_b <= 1'b0;
			timer_a_interrupt <= 1'b0;
			timer_b_interrupt <= 1'b0;
		end
		else
		begin
			// Pins take the next level so the period-match edge meets its interrupt
			pulse_output_pin_a <= next_lvl[0];
			pulse_output_pin_b <= and_sel ? (&next_lvl) : next_lvl[1];
			timer_a_interrupt <= ev_pd[0];
			timer_b_interrupt <= ev_pd[1] | wide_ev;
		end
	end

endmodule
`default_nettype wire

// [bench/ppg_pair_checker.sv]
// Checker for ppg_pair: bus answers and timer interrupt events.
// Assumes the ppg_pair ports only; attached by the bind at the foot.
`timescale 1ns/1ps
`default_nettype none
module ppg_pair_checker
(
	input wire logic        clk,                // Clock
	input wire logic        sys_rst,            // Reset
	input wire logic        awvalid,            // Write addr valid
	input wire logic        awready,            // Write addr ready
	input wire logic        wvalid,             // Write data valid
	input wire logic        wready,             // Write data ready
	input wire logic [1:0]  bresp,              // Write response
	input wire logic        bvalid,             // Response valid
	input wire logic        bready,             // Response ready
	input wire logic        arvalid,            // Read addr valid
	input wire logic        arready,            // Read addr ready
	input wire logic [31:0] rdata,              // Read data
	input wire logic        rvalid,             // Read valid
	input wire logic        rready,             // Read ready
	input wire logic        pulse_output_pin_a, // Timer A pin
	input wire logic        timer_a_interrupt,  // Timer A event
	input wire logic        timer_b_interrupt   // Timer B event
);
	default clocking dc @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence wr_taken;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence rd_taken;
		arvalid && arready;
	endsequence

	a_bresp_holds:
		assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	a_rdata_holds:
		assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped early");
	a_write_answer:
		assert property (wr_taken |-> ##[1:3] bvalid)
		else $error("write response missing");
	a_read_answer:
		assert property (rd_taken |-> ##[1:2] rvalid)
		else $error("read data missing");
	a_read_blocked:
		assert property (rvalid |-> !arready)
		else $error("read address taken while data pending");
	a_int_a_single:
		assert property (timer_a_interrupt |=> !timer_a_interrupt)
		else $error("timer A event longer than one cycle");
	a_int_b_single:
		assert property (timer_b_interrupt |=> !timer_b_interrupt)
		else $error("timer B event longer than one cycle");
	a_pin_a_event:
		assert property (timer_a_interrupt |-> $changed(pulse_output_pin_a))
		else $error("timer A pin did not return with its event");
endmodule

bind ppg_pair ppg_pair_checker u_chk
(
	.clk, .sys_rst, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid,
	.bready, .arvalid, .arready, .rdata, .rvalid, .rready,
	.pulse_output_pin_a, .timer_a_interrupt, .timer_b_interrupt
);
`default_nettype wire

// [bench/tb_top.sv]
// Self-checking bench for ppg_pair, one task per scenario.
// Assumes clock select 7 ticks on every clk, so intervals are in clocks.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [5:0] MA = ppg_pair_pkg::OFF_MODE_A;
	localparam logic [5:0] MB = ppg_pair_pkg::OFF_MODE_B;
	localparam logic [5:0] PC = ppg_pair_pkg::OFF_PAIR;
	localparam logic [5:0] PA = ppg_pair_pkg::OFF_PERIOD_A;
	localparam logic [5:0] DA = ppg_pair_pkg::OFF_DUTY_A;
	localparam logic [5:0] PB = ppg_pair_pkg::OFF_PERIOD_B;
	localparam logic [5:0] DB = ppg_pair_pkg::OFF_DUTY_B;
	localparam logic [5:0] ST = ppg_pair_pkg::OFF_STATUS;
	logic        clk = 1'h0;
	logic        sys_rst = 1'h1;
	logic [5:0]  awaddr = 6'h00;
	logic [5:0]  araddr = 6'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'hF;
	logic        awvalid = 1'h0;
	logic        wvalid = 1'h0;
	logic        bready = 1'h0;
	logic        arvalid = 1'h0;
	logic        rready = 1'h0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata, rd_val;
	logic        pulse_output_pin_a, pulse_output_pin_b;
	logic        timer_a_interrupt, timer_b_interrupt;
	int          n_errors = 0;
	int          tests_run = 0;
	int          cycles = 0;
	int          len, hi;
	logic [1:0]  rsp;

	ppg_pair u_dut
	(
		.clk, .sys_rst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .pulse_output_pin_a,
		.pulse_output_pin_b, .timer_a_interrupt, .timer_b_interrupt
	);

	always #2.5 clk = ~clk;

	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Whole run needs a few thousand clocks; ceiling leaves wide margin
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			n_errors = n_errors + 1;
			finish_test();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do
		begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'h0;
			if (wready)
				wvalid <= 1'h0;
		end
		while (!bvalid);
		bready <= 1'h0;
		rd_val = {30'h0, bresp};
	endtask

	task automatic rd(input logic [5:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do
		begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'h0;
		end
		while (!rvalid);
		rready <= 1'h0;
		rd_val = rdata;
		rsp = rresp;
	endtask

	// Clocks from one event to the next, and pin high clocks between
	task automatic measure(input logic b);
		len = 0;
		hi = 0;
		@(posedge clk);
		while (!(b ? timer_b_interrupt : timer_a_interrupt))
			@(posedge clk);
		do
		begin
			@(posedge clk);
			len++;
			hi += b ? pulse_output_pin_b : pulse_output_pin_a;
		end
		while (!(b ? timer_b_interrupt : timer_a_interrupt));
	endtask

	task automatic t_reset();
		rd(MA);
		check(rd_val, 32'h0);
		check({30'h0, rsp}, {30'h0, ppg_pair_pkg::RESP_OKAY});
		rd(PA);
		check(rd_val, 32'hFF);
		rd(ST);
		check(rd_val, 32'h0);
		rd(6'h20);
		check(rd_val, 32'h0);
		check({30'h0, rsp}, {30'h0, ppg_pair_pkg::RESP_SLVERR});
		wr(6'h24, 32'h1);
		check(rd_val, {30'h0, ppg_pair_pkg::RESP_SLVERR});
		$display("Reset test done");
	endtask

	task automatic t_ppg_a();
		wr(DA, 32'h3);
		wr(PA, 32'h8);
		wr(MA, 32'h3A);
		wr(PC, 32'h1);
		measure(1'h0);
		check(len, 32'h9);
		check(hi, 32'h5);
		wr(MA, 32'hBA);
		wr(PC, 32'h0);
		rd(ST);
		check(rd_val, 32'h0);
		wr(MA, 32'hBA);
		rd(ST);
		check(rd_val, 32'h10000);
		$display("Timer A pulse test done");
	endtask

	task automatic t_buf_a();
		wr(MA, 32'h7A);
		wr(PA, 32'h8);
		wr(PC, 32'h1);
		measure(1'h0);
		check(len, 32'h9);
		wr(PA, 32'h4);
		rd(PA);
		check(rd_val, 32'h4);
		measure(1'h0);
		check(len, 32'h5);
		wr(PC, 32'h0);
		$display("Timer A buffer test done");
	endtask

	// A high 3 clocks, B high 5, so the pin shows only the overlap
	task automatic t_and();
		wr(MA, 32'h3A);
		wr(PA, 32'h8);
		wr(DA, 32'h5);
		wr(MB, 32'h3A);
		wr(PB, 32'h8);
		wr(DB, 32'h3);
		wr(PC, 32'hB);
		measure(1'h1);
		check(len, 32'h9);
		check(hi, 32'h3);
		wr(PC, 32'h0);
		$display("AND output test done");
	endtask

	task automatic t_wide();
		wr(MB, 32'h38);
		wr(PA, 32'h10);
		wr(PB, 32'h0);
		wr(PC, 32'h6);
		measure(1'h1);
		check(len, 32'h11);
		rd(PA);
		check(rd_val, 32'h10);
		wr(PC, 32'h4);
		rd(ST);
		check(rd_val, 32'h0);
		wr(MB, 32'h79);
		wr(PA, 32'h8);
		wr(PB, 32'h0);
		wr(PC, 32'h6);
		measure(1'h1);
		check(len, 32'h9);
		wr(PA, 32'h20);
		wr(PB, 32'h0);
		measure(1'h1);
		check(len, 32'h21);
		wr(PC, 32'h0);
		$display("Wide timer test done");
	endtask

	// Slowest source keeps the count still while the duty write lands
	task automatic t_equal();
		wr(MA, 32'h02);
		wr(PA, 32'h80);
		wr(DA, 32'h80);
		wr(PC, 32'h1);
		do
			rd(ST);
		while (rd_val[7:0] == 8'h00);
		wr(DA, 32'h1);
		rd(ST);
		check(rd_val, 32'h10001);
		wr(PC, 32'h0);
		$display("Equal write test done");
	endtask

	initial
	begin
		repeat (16) @(posedge clk);
		sys_rst <= 1'h0;
		t_reset();
		t_ppg_a();
		t_buf_a();
		t_and();
		t_wide();
		t_equal();
		finish_test();
	end
endmodule
`default_nettype wire
